// ---- core/urs_core.sv ----
// Function
// - Two cascaded counters, 72 rate choices
// - Prescaler divides by 1, 3, 4, 5
// - Divisor counter offers seventeen listed ratios
// - External divisor passes prescaler output through
// - Generator output is sixteen times bit rate
// - Clock-out selects oscillator or generator clock
// - Fifty percent duty except external with 3/5 and odd fractional lengths
// - Modem control readable; RTS/DTR ones drive low
// - Interrupt held low while global enable clear
// - Break mode holds serial output low
// - Echo copies serial input, disables transmitter
// - Loop mode routes transmit to receiver internally
// - Receiver enable clear blocks serial input
// - Modem enable lets CTS/DSR changes interrupt
// - Error flags updated per character at stop
// - Framing and parity error flags set properly
// - Break flag when whole character zero
// - Modem change flag always set; its interrupt gated by both enables
// - Transmission complete flag raises interrupt
// - Holding empty, data ready never interrupt
// - Modem status shows inverted low-true inputs
// - CTS high stops new characters starting
// - Rate bit 7 is clock-out select, reset clear
// - Line status read clears bits and edges
// - Modem status read clears change detector only
`include "urs_params.svh"

module urs_core
	import urs_pkg::*;
#(
	parameter int DIV_W = `URS_DIV_W
) (
	// Clock, reset, enable
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic       clkEn,
	// Oscillator and clock out
	input  wire logic       oscInputPin,
	output logic            clockOutPin,
	// Parallel register port
	input  wire logic       chipSel_n,
	input  wire logic       rd_n,
	input  wire logic       wr_n,
	input  wire logic [1:0] addr,
	input  wire logic [7:0] dataIn,
	output logic [7:0]      dataOut,
	output logic            dataOe_n,
	// Modem lines
	input  wire logic       cts_n,
	input  wire logic       dsr_n,
	output logic            rts_n,
	output logic            dtr_n,
	output logic            irqOut,
	// Serial pins
	input  wire logic       serialInPin,
	output logic            serialOutPin,
	// Transmitter side
	input  wire logic       txSerial,
	input  wire logic       txIdle,
	input  wire logic       txHoldEmpty,
	output logic            txStartPermit,
	output logic            txBreakMode,
	output logic            txEnable,
	output logic            txHoldWrite,
	// Receiver side
	input  wire logic       rxCharDone,
	input  wire logic       rxOverrun,
	input  wire logic       rxFraming,
	input  wire logic       rxParity,
	input  wire logic       rxBreak,
	input  wire logic       rxReady,
	input  wire logic [7:0] rxHoldData,
	output logic            rxSerial,
	output logic            rxHoldRead,
	// Other register strobes
	output logic            ctrlWrite,
	output logic [7:0]      busWrData,
	// Generator outputs
	output logic            baudTick,
	output logic            baudClk
);

	localparam int SYNC_W = 17;

	// Synchroniser stages for every outside pin
	logic [SYNC_W-1:0] syncA_q;
	logic [SYNC_W-1:0] syncB_q;
	logic              csS;
	logic              rdS;
	logic              wrS;
	logic [1:0]        addrS;
	logic [7:0]        dataS;
	logic              ctsS_n;
	logic              dsrS_n;
	logic              serS;
	logic              oscS;
	logic              oscPrev_q;
	logic              oscRise;

	// Bus cycle tracking
	logic              rdActive;
	logic              wrActive;
	logic              rdPrev_q;
	logic              wrPrev_q;
	logic [1:0]        rdAddr_q;
	logic [1:0]        wrAddr_q;
	logic [7:0]        wrData_q;
	logic              rdEnd;
	logic              wrEnd;
	logic [7:0]        dataOut_q;
	logic              holdRead_q;
	logic              holdWrite_q;
	logic              ctrlWrite_q;

	// Registers
	logic              coSel_q;
	logic [6:0]        rateSel_q = 7'h00;
	logic [7:0]        mcr_q;
	logic [7:0]        lsr_q;
	logic [3:0]        lsrErr_q;
	logic [7:4]        lsrEvt_q;
	logic [1:0]        modemPrev_q;
	logic              txIdlePrev_q;
	logic              tbePrev_q;
	logic              rdyPrev_q;
	logic [4:0]        irqPrev_q;
	logic              lineEdge_q;
	logic              modemEdge_q;
	logic              irq_q;

	// Decoded fields and events
	urs_mode_t         mode;
	logic [1:0]        msrLive;
	logic              modemChange;
	logic              lsrClr;
	logic              msrClr;
	logic [4:0]        irqBits;
	logic              baudClkGen;

	// Register read decode, used only for the bus read data register
	function automatic logic [7:0] regRead(input logic [1:0] a,
			input logic [7:0] hold, input logic [7:0] modem_control_reg,
			input logic [7:0] lsr, input logic [1:0] modem_line_status_reg);
		logic [7:0] v;
		v = 8'h00;
		unique case (a)
			`URS_ADDR_HOLD:      v = hold;
			`URS_ADDR_LINE:      v = lsr;
			`URS_ADDR_MODEM_CTL: v = modem_control_reg;
			`URS_ADDR_RATE:      v = {6'h00, modem_line_status_reg};
		endcase
		return v;
	endfunction : regRead

	// Two flip-flops on every asynchronous pin; only echo uses the raw serial input
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			syncA_q <= {SYNC_W{1'b1}};
			syncB_q <= {SYNC_W{1'b1}};
		end else if (clkEn) begin
			syncA_q <= {oscInputPin, serialInPin, dsr_n, cts_n, dataIn, addr,
				wr_n, rd_n, chipSel_n};
			syncB_q <= syncA_q;
		end
	end

	assign csS    = ~syncB_q[0];
	assign rdS    = ~syncB_q[1];
	assign wrS    = ~syncB_q[2];
	assign addrS  = syncB_q[4:3];
	assign dataS  = syncB_q[12:5];
	assign ctsS_n = syncB_q[13];
	assign dsrS_n = syncB_q[14];
	assign serS   = syncB_q[15];
	assign oscS   = syncB_q[16];

	// Oscillator edge for the rate counters
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			oscPrev_q <= 1'b1;  // Matches synchroniser reset, no false edge
		end else if (clkEn) begin
			oscPrev_q <= oscS;
		end
	end

	assign oscRise = oscS && !oscPrev_q;

	// Strobes act at the trailing edge, so status clearing is
	// held off until the read cycle is over
	assign rdActive = csS && rdS;
	assign wrActive = csS && wrS;
	assign rdEnd    = rdPrev_q && !rdActive;
	assign wrEnd    = wrPrev_q && !wrActive;
	assign lsrClr   = rdEnd && (rdAddr_q == `URS_ADDR_LINE);
	assign msrClr   = rdEnd && (rdAddr_q == `URS_ADDR_RATE);

	// Latch address and data while the strobe is low
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rdPrev_q <= 1'b0;
			wrPrev_q <= 1'b0;
			rdAddr_q <= 2'h0;
			wrAddr_q <= 2'h0;
			wrData_q <= 8'h00;
		end else if (clkEn) begin
			rdPrev_q <= rdActive;
			wrPrev_q <= wrActive;
			if (rdActive) begin
				rdAddr_q <= addrS;
			end
			if (wrActive) begin
				wrAddr_q <= addrS;
				wrData_q <= dataS;
			end
		end
	end

	// Read data register, driven while the read strobe is low
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			dataOut_q <= 8'h00;
		end else if (clkEn && rdActive) begin
			dataOut_q <= regRead(addrS, rxHoldData, mcr_q, lsr_q, msrLive);
		end
	end

	assign dataOut  = dataOut_q;
	assign dataOe_n = !rdPrev_q;  // Low while driving the bus

	// One-cycle strobes to the holding registers and character format
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			holdRead_q  <= 1'b0;
			holdWrite_q <= 1'b0;
			ctrlWrite_q <= 1'b0;
		end else if (clkEn) begin
			holdRead_q  <= rdEnd && (rdAddr_q == `URS_ADDR_HOLD);
			holdWrite_q <= wrEnd && (wrAddr_q == `URS_ADDR_HOLD);
			ctrlWrite_q <= wrEnd && (wrAddr_q == `URS_ADDR_LINE);
		end
	end

	assign rxHoldRead  = holdRead_q;
	assign txHoldWrite = holdWrite_q;
	assign ctrlWrite   = ctrlWrite_q;
	assign busWrData   = wrData_q;

	// Rate select: reset clears only the clock-out select
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			coSel_q <= 1'b0;
		end else if (clkEn && wrEnd && wrAddr_q == `URS_ADDR_RATE) begin
			coSel_q <= wrData_q[`URS_RATE_CO_SEL];
		end
	end

	// Ratio bits keep their value across reset
	always_ff @(posedge clk_sys) begin
		if (clkEn && wrEnd && wrAddr_q == `URS_ADDR_RATE) begin
			rateSel_q <= wrData_q[6:0];
		end
	end

	// Modem control; top bit is stored as written, host keeps it zero
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			mcr_q <= `URS_MCR_RESET;
		end else if (clkEn && wrEnd && wrAddr_q == `URS_ADDR_MODEM_CTL) begin
			mcr_q <= wrData_q;
		end
	end

	assign mode = urs_mode_t'(mcr_q[`URS_MCR_MODE_LSB +: 2]);

	// Written one asserts the low-true pin
	assign rts_n = ~mcr_q[`URS_MCR_RTS];
	assign dtr_n = ~mcr_q[`URS_MCR_DTR];

	// Live modem image, inverted
	assign msrLive = {~dsrS_n, ~ctsS_n};

	// Any change of either modem input
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			modemPrev_q <= 2'h0;
		end else if (clkEn) begin
			modemPrev_q <= msrLive;
		end
	end

	assign modemChange = |(msrLive ^ modemPrev_q);

	// Previous levels of the transmitter and receiver conditions
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			txIdlePrev_q <= 1'b1;
			tbePrev_q    <= 1'b1;
			rdyPrev_q    <= 1'b0;
		end else if (clkEn) begin
			txIdlePrev_q <= txIdle;
			tbePrev_q    <= txHoldEmpty;
			rdyPrev_q    <= rxReady;
		end
	end

	// Error and break flags: rewritten per character, cleared by read;
	// a new character in the clearing cycle wins
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			lsrErr_q <= 4'(`URS_LSR_RESET);
		end else if (clkEn) begin
			if (rxCharDone) begin
				lsrErr_q[`URS_LSR_OE]  <= rxOverrun;
				lsrErr_q[`URS_LSR_FE]  <= rxFraming;
				lsrErr_q[`URS_LSR_PE]  <= rxParity;
				lsrErr_q[`URS_LSR_BRK] <= rxBreak;
			end else if (lsrClr) begin
				lsrErr_q <= 4'h0;
			end
		end
	end

	// Event flags: set wins over a read clear
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			lsrEvt_q <= 4'(`URS_LSR_RESET >> 4);
		end else if (clkEn) begin
			if (modemChange) begin
				lsrEvt_q[`URS_LSR_MS] <= 1'b1;
			end else if (lsrClr) begin
				lsrEvt_q[`URS_LSR_MS] <= 1'b0;
			end
			if (txIdle && !txIdlePrev_q) begin
				lsrEvt_q[`URS_LSR_TC] <= 1'b1;
			end else if (lsrClr) begin
				lsrEvt_q[`URS_LSR_TC] <= 1'b0;
			end
			if (txHoldEmpty && !tbePrev_q) begin
				lsrEvt_q[`URS_LSR_TX_HOLDING_EMPTY_FLAG] <= 1'b1;
			end else if (lsrClr) begin
				lsrEvt_q[`URS_LSR_TX_HOLDING_EMPTY_FLAG] <= 1'b0;
			end
			if (rxReady && !rdyPrev_q) begin
				lsrEvt_q[`URS_LSR_DR] <= 1'b1;
			end else if (lsrClr) begin
				lsrEvt_q[`URS_LSR_DR] <= 1'b0;
			end
		end
	end

	// Two halves kept apart so each has a single writing process
	assign lsr_q = {lsrEvt_q, lsrErr_q};

	// Status bits that may interrupt; TX_HOLDING_EMPTY_FLAG and DR left out
	assign irqBits = {lsr_q[`URS_LSR_TC], lsr_q[`URS_LSR_BRK], lsr_q[`URS_LSR_OE],
		lsr_q[`URS_LSR_FE], lsr_q[`URS_LSR_PE]};

	// Rising-edge detector on status bits; the reset-set TC makes an
	// edge too, so software reads status before enabling interrupts
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			irqPrev_q  <= 5'h00;
			lineEdge_q <= 1'b0;
		end else if (clkEn) begin
			irqPrev_q <= irqBits;
			if (|(irqBits & ~irqPrev_q)) begin
				lineEdge_q <= 1'b1;
			end else if (lsrClr) begin
				lineEdge_q <= 1'b0;
			end
		end
	end

	// Modem change detector; either status read clears it
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			modemEdge_q <= 1'b0;
		end else if (clkEn) begin
			if (modemChange) begin
				modemEdge_q <= 1'b1;
			end else if (msrClr || lsrClr) begin
				modemEdge_q <= 1'b0;
			end
		end
	end

	// Interrupt request, gated by the global and modem enables
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			irq_q <= 1'b0;
		end else if (clkEn) begin
			irq_q <= mcr_q[`URS_MCR_GLOBAL_IRQ_ENABLE] && (lineEdge_q ||
				(mcr_q[`URS_MCR_MODEM_IRQ_ENABLE] && modemEdge_q));
		end
	end

	assign irqOut = irq_q;

	// Two-counter rate generator
	urs_rate_gen #(
		.DIV_W    (DIV_W)
	) u_rate_gen (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.clkEn    (clkEn),
		.oscLevel (oscS),
		.oscRise  (oscRise),
		.preSel   (urs_pre_t'(rateSel_q[`URS_RATE_PRE_LSB +: 2])),
		.divSel   (rateSel_q[`URS_RATE_DIV_LSB +: 5]),
		.baudTick (baudTick),
		.baudClk  (baudClkGen)
	);

	assign baudClk = baudClkGen;

	// Clock out: synchronised copy of the oscillator or the 16x clock
	assign clockOutPin = coSel_q ? baudClkGen : oscS;

	// Serial output per mode; echo uses the raw pin, not resynchronised
	always_comb begin
		unique case (mode)
			URS_MODE_NORMAL: serialOutPin = txSerial;
			URS_MODE_BREAK:  serialOutPin = 1'b0;
			URS_MODE_ECHO:   serialOutPin = serialInPin;
			URS_MODE_LOOP:   serialOutPin = 1'b1;
		endcase
	end

	// Receiver input: loopback, gated pin, or idle mark
	always_comb begin
		if (mode == URS_MODE_LOOP) begin
			rxSerial = txSerial;
		end else if (!mcr_q[`URS_MCR_RX_EN]) begin
			rxSerial = 1'b1;
		end else begin
			rxSerial = serS;
		end
	end

	// Transmitter controls; it finishes a character already begun
	assign txStartPermit = !ctsS_n;
	assign txBreakMode   = (mode == URS_MODE_BREAK);
	assign txEnable      = (mode != URS_MODE_ECHO);

endmodule : urs_core

// ---- core/urs_params.svh ----
`ifndef URS_PARAMS_SVH
`define URS_PARAMS_SVH

// Register select codes on the two address pins
`define URS_ADDR_HOLD       2'h0
`define URS_ADDR_LINE       2'h1
`define URS_ADDR_MODEM_CTL  2'h2
`define URS_ADDR_RATE       2'h3

// Rate select register fields
`define URS_RATE_CO_SEL     7
`define URS_RATE_PRE_LSB    5
`define URS_RATE_DIV_LSB    0

// Modem control register fields
`define URS_MCR_DTR         0
`define URS_MCR_RTS         1
`define URS_MCR_MODE_LSB    2
`define URS_MCR_RX_EN       4
`define URS_MCR_MODEM_IRQ_ENABLE        5
`define URS_MCR_GLOBAL_IRQ_ENABLE       6
`define URS_MCR_RESET       8'h00

// Line status register fields
`define URS_LSR_PE          0
`define URS_LSR_FE          1
`define URS_LSR_OE          2
`define URS_LSR_BRK         3
`define URS_LSR_MS          4
`define URS_LSR_TC          5
`define URS_LSR_TX_HOLDING_EMPTY_FLAG        6
`define URS_LSR_DR          7
`define URS_LSR_RESET       8'h60

// Modem line status register fields
`define URS_MSR_CTS         0
`define URS_MSR_DSR         1

// Divisor counter width, enough for the largest ratio
`define URS_DIV_W           10

`endif

// ---- core/urs_pkg.sv ----
package urs_pkg;

	// Operating modes held in the modem control register
	typedef enum logic [1:0] {
		URS_MODE_NORMAL = 2'h0,
		URS_MODE_BREAK  = 2'h1,
		URS_MODE_ECHO   = 2'h2,
		URS_MODE_LOOP   = 2'h3
	} urs_mode_t;

	// Prescaler ratios
	typedef enum logic [1:0] {
		URS_PRE_1 = 2'h0,
		URS_PRE_3 = 2'h1,
		URS_PRE_4 = 2'h2,
		URS_PRE_5 = 2'h3
	} urs_pre_t;

endpackage : urs_pkg

// ---- core/urs_rate_gen.sv ----
`include "urs_params.svh"

module urs_rate_gen
	import urs_pkg::*;
#(
	parameter int DIV_W = `URS_DIV_W
) (
	// Clock, reset, enable
	input  wire logic             clk_sys,
	input  wire logic             rst,
	input  wire logic             clkEn,
	// Synchronised oscillator
	input  wire logic             oscLevel,
	input  wire logic             oscRise,
	// Ratio selects
	input  wire urs_pre_t         preSel,
	input  wire logic [4:0]       divSel,
	// Generator output
	output logic                  baudTick,
	output logic                  baudClk
);

	logic [2:0]       preCnt_q;
	logic [DIV_W-1:0] divCnt_q;
	logic [1:0]       phase_q;
	logic             baudClk_q;
	logic             preTick;
	logic             preLevel;
	logic             divWrap;
	logic [DIV_W-1:0] curLen;
	logic [2:0]       preLen;

	// Length in prescaler ticks of one output period; fractional ratios
	// cycle over three periods so the average is exact
	function automatic logic [DIV_W-1:0] divLen(input logic [4:0] sel,
			input logic [1:0] ph);
		logic [DIV_W-1:0] len;
		len = DIV_W'(1);
		unique case (sel)
			5'h01: len = DIV_W'(2);
			5'h02: len = DIV_W'(4);
			5'h03: len = (ph == 2'h2) ? DIV_W'(6) : DIV_W'(5);
			5'h04: len = DIV_W'(8);
			5'h05: len = (ph == 2'h2) ? DIV_W'(10) : DIV_W'(11);
			5'h06: len = DIV_W'(16);
			5'h07: len = (ph == 2'h2) ? DIV_W'(20) : DIV_W'(19);
			5'h08: len = DIV_W'(22);
			5'h09: len = DIV_W'(32);
			5'h0a: len = DIV_W'(64);
			5'h0b: len = DIV_W'(128);
			5'h0c: len = DIV_W'(192);
			5'h0d: len = DIV_W'(256);
			5'h0e: len = DIV_W'(288);
			5'h0f: len = DIV_W'(352);
			5'h10: len = DIV_W'(512);
			5'h11: len = DIV_W'(768);
			default: len = DIV_W'(1); // External and unused codes
		endcase
		return len;
	endfunction : divLen

	// Prescaler ratio
	always_comb begin
		unique case (preSel)
			URS_PRE_1: preLen = 3'h1;
			URS_PRE_3: preLen = 3'h3;
			URS_PRE_4: preLen = 3'h4;
			URS_PRE_5: preLen = 3'h5;
		endcase
	end

	// Compare as at-or-above so a ratio change never strands a counter
	assign preTick  = oscRise && (preCnt_q >= preLen - 3'h1);
	// Prescale ratios 3 and 5 give an uneven high phase
	assign preLevel = (preSel == URS_PRE_1) ? oscLevel : (preCnt_q < (preLen >> 1));
	assign curLen   = divLen(divSel, phase_q);
	assign divWrap  = preTick && (divCnt_q >= curLen - DIV_W'(1));

	// First counter: prescaler
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			preCnt_q <= 3'h0;
		end else if (clkEn && oscRise) begin
			preCnt_q <= preTick ? 3'h0 : preCnt_q + 3'h1;
		end
	end

	// Second counter: divisor select
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			divCnt_q <= '0;
			phase_q  <= 2'h0;
		end else if (clkEn && preTick) begin
			divCnt_q <= divWrap ? '0 : divCnt_q + DIV_W'(1);
			if (divWrap) begin
				phase_q <= (phase_q == 2'h2) ? 2'h0 : phase_q + 2'h1;
			end
		end
	end

	// Half-length high phase gives a 50% duty cycle for even lengths
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			baudClk_q <= 1'b0;
		end else if (clkEn) begin
			baudClk_q <= (divCnt_q < (curLen >> 1));
		end
	end

	// External code passes prescaler straight through
	assign baudTick = (curLen == DIV_W'(1)) ? preTick : divWrap;
	assign baudClk  = (curLen == DIV_W'(1)) ? preLevel : baudClk_q;

endmodule : urs_rate_gen

// ---- test/uart_rate_mode_status_logic_bench.sv ----
module uart_rate_mode_status_logic_bench;
	timeunit 1ns;
	timeprecision 100ps;

	// Design pins
	logic       clk_sys, rst, clkEn, oscInputPin, chipSel_n, rd_n, wr_n;
	logic [1:0] addr;
	logic [7:0] dataIn, dataOut, rxHoldData, busWrData;
	logic       dataOe_n, cts_n, dsr_n, rts_n, dtr_n, irqOut, serialInPin, serialOutPin;
	logic       txSerial, txIdle, txHoldEmpty, rxCharDone, rxOverrun, rxFraming, rxParity;
	logic       rxBreak, rxReady, clockOutPin, rxSerial, baudTick, baudClk;
	int         checked, miscompares, oscCnt;

	urs_core urs_core_inst (
		.clk_sys, .rst, .clkEn, .oscInputPin, .clockOutPin, .chipSel_n, .rd_n, .wr_n, .addr,
		.dataIn, .dataOut, .dataOe_n, .cts_n, .dsr_n, .rts_n, .dtr_n, .irqOut, .serialInPin,
		.serialOutPin, .txSerial, .txIdle, .txHoldEmpty, .txStartPermit(), .txBreakMode(),
		.txEnable(), .txHoldWrite(), .rxCharDone, .rxOverrun, .rxFraming, .rxParity, .rxBreak,
		.rxReady, .rxHoldData, .rxSerial, .rxHoldRead(), .ctrlWrite(), .busWrData, .baudTick,
		.baudClk
	);
	urs_modem_model urs_modem_model_inst (.clk_sys, .cts_n, .dsr_n, .serialInPin);

	// System clock
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	// Oscillator at a tenth of the system rate, well inside what the sync stage can count
	initial begin
		{oscInputPin, txSerial} = '0;
		oscCnt = 0;
		forever begin
			@(posedge clk_sys);
			oscCnt = (oscCnt + 1) % 5;
			if (oscCnt == 0) oscInputPin <= #1 ~oscInputPin;
			txSerial <= #1 ~txSerial;
		end
	end

	// Advance to just after a rising edge
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : step

	// Comparisons
	task automatic cmp8(input logic [7:0] got, exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp8
	task automatic cmpBit(input logic got, exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmpBit

	// Verdict and stop
	task automatic end_of_test;
		$display("Comparisons %0d, mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_of_test

	// Register cycles; strobes held well beyond the three-cycle minimum
	task automatic regWr(input logic [1:0] a, input logic [7:0] d);
		chipSel_n = 1'b0;
		wr_n = 1'b0;
		addr = a;
		dataIn = d;
		step(4);
		wr_n = 1'b1;
		chipSel_n = 1'b1;
		step(4);
	endtask : regWr
	task automatic regRd(input logic [1:0] a, output logic [7:0] d);
		chipSel_n = 1'b0;
		rd_n = 1'b0;
		addr = a;
		step(5);
		cmpBit(dataOe_n, 1'b0);
		d = dataOut;
		rd_n = 1'b1;
		chipSel_n = 1'b1;
		step(6);
		cmpBit(dataOe_n, 1'b1);
	endtask : regRd

	// Bounded wait for the interrupt; running out ends the run
	task automatic waitIrq;
		for (int i = 0; i < 20 && irqOut !== 1'b1; i++) step(1);
		cmpBit(irqOut, 1'b1);
		if (irqOut !== 1'b1) end_of_test();
	endtask : waitIrq

	// Cycles across n generator ticks, with high time and clock-out disagreements
	task automatic measure(input int n, output int span, high, diff);
		int k;
		k = 0;
		span = 0;
		high = 0;
		diff = 0;
		for (int i = 0; i < 400 && baudTick !== 1'b1; i++) step(1);
		if (baudTick !== 1'b1) miscompares++;
		if (baudTick !== 1'b1) end_of_test();
		while (k < n && span < 400) begin
			step(1);
			span++;
			high += int'(baudClk === 1'b1);
			diff += int'(clockOutPin !== baudClk);
			k += int'(baudTick === 1'b1);
		end
	endtask : measure

	// Status after reset, then cleared by its own read
	task automatic testReset;
		logic [7:0] d;
		regRd(2'h1, d);
		cmp8(d, 8'h60);
		regRd(2'h1, d);
		cmp8(d, 8'h00);
		regRd(2'h2, d);
		cmp8(d, 8'h00);
	endtask : testReset

	// Every operating mode with line outputs, then receiver disabled
	task automatic testModes;
		logic [7:0] d, e;
		for (int m = 0; m < 4; m++) begin
			e = 8'h10 | 8'(m * 5);
			regWr(2'h2, e);
			regRd(2'h2, d);
			cmp8(d, e);
			cmp8(busWrData, e);
			cmpBit(rts_n, !e[1]);
			cmpBit(dtr_n, !e[0]);
			urs_modem_model_inst.lines(1'b1, 1'b1, 1'b0, 2);
			step(4);
			if (m != 0) cmpBit(serialOutPin, m == 3);
			urs_modem_model_inst.lines(1'b1, 1'b1, 1'b1, 0);
			step(4);
			if (m == 2) cmpBit(serialOutPin, 1'b1);
		end
		regWr(2'h2, 8'h00);
		urs_modem_model_inst.lines(1'b1, 1'b1, 1'b0, 0);
		step(4);
		cmpBit(rxSerial, 1'b1);
		urs_modem_model_inst.lines(1'b1, 1'b1, 1'b1, 0);
	endtask : testModes

	// Modem change interrupt, its gating and the two status reads
	task automatic testModem;
		logic [7:0] d;
		regWr(2'h2, 8'h60);
		regRd(2'h1, d);
		urs_modem_model_inst.lines(1'b0, 1'b1, 1'b1, 3);
		waitIrq();
		regRd(2'h3, d);
		cmp8(d & 8'h03, 8'h01);
		cmpBit(irqOut, 1'b0);
		regRd(2'h1, d);
		cmp8(d, 8'h10);
		regWr(2'h2, 8'h40);
		urs_modem_model_inst.lines(1'b0, 1'b0, 1'b1, 0);
		step(8);
		cmpBit(irqOut, 1'b0);
		regRd(2'h1, d);
		cmp8(d, 8'h10);
		regRd(2'h3, d);
		cmp8(d & 8'h03, 8'h03);
	endtask : testModem

	// Transmit done, ready flags and receive errors against the interrupt
	task automatic testEvents;
		logic [7:0] d;
		regWr(2'h2, 8'h00);
		txIdle = 1'b0;
		step(2);
		txIdle = 1'b1;
		step(8);
		cmpBit(irqOut, 1'b0);
		regRd(2'h1, d);
		cmp8(d, 8'h20);
		regWr(2'h2, 8'h40);
		txIdle = 1'b0;
		step(2);
		txIdle = 1'b1;
		waitIrq();
		regRd(2'h1, d);
		cmp8(d, 8'h20);
		cmpBit(irqOut, 1'b0);
		txHoldEmpty = 1'b0;
		step(2);
		txHoldEmpty = 1'b1;
		rxReady = 1'b1;
		step(8);
		cmpBit(irqOut, 1'b0);
		regRd(2'h1, d);
		cmp8(d, 8'hc0);
		for (int i = 0; i < 4; i++) begin
			{rxBreak, rxOverrun, rxFraming, rxParity} = 4'h1 << i;
			rxCharDone = 1'b1;
			step(1);
			rxCharDone = 1'b0;
			{rxBreak, rxOverrun, rxFraming, rxParity} = 4'h0;
			waitIrq();
			regRd(2'h1, d);
			cmp8(d, 8'h01 << i);
		end
	endtask : testEvents

	// Divide ratios, duty, clock-out choice; the fractional ratio is timed over three ticks
	task automatic testRate;
		logic [7:0] rate [6];
		int         per [6], hi [6], span, high, diff, flips;
		logic       last;
		rate = '{8'h80, 8'h81, 8'hc2, 8'ha1, 8'h83, 8'he0};
		per = '{10, 20, 160, 60, 160, 50};
		hi = '{5, 10, 80, 30, 0, 0};
		for (int n = 0; n < 6; n++) begin
			regWr(2'h3, rate[n]);
			step(200);
			measure(n == 4 ? 3 : 1, span, high, diff);
			cmp8(8'(span), 8'(per[n]));
			if (hi[n] > 0) cmp8(8'(high), 8'(hi[n]));
			cmp8(8'(diff), 8'h00);
		end
		regWr(2'h3, 8'h01);
		flips = 0;
		last = clockOutPin;
		repeat (40) begin
			step(1);
			flips += int'(clockOutPin !== last);
			last = clockOutPin;
		end
		cmp8(8'(flips), 8'h08);
	endtask : testRate

	// Main sequence
	initial begin
		{rxCharDone, rxOverrun, rxFraming} = '0;
		{rxParity, rxBreak, rxReady} = '0;
		{rst, clkEn, chipSel_n, rd_n, wr_n, txIdle, txHoldEmpty} = '1;
		addr = 2'h0;
		dataIn = 8'h00;
		rxHoldData = 8'h5a;
		checked = 0;
		miscompares = 0;
		step(2);
		rst = 1'b0;
		step(3);
		testReset();
		testModes();
		testModem();
		testEvents();
		testRate();
		end_of_test();
	end
endmodule : uart_rate_mode_status_logic_bench

// ---- test/urs_core_monitor.sv ----
module urs_core_monitor
	import urs_pkg::*;
(
	// Clock and reset
	input wire logic       clk_sys,
	input wire logic       rst,
	// Register port
	input wire logic       chipSel_n,
	input wire logic       wr_n,
	input wire logic [1:0] addr,
	input wire logic [7:0] dataIn,
	input wire logic       dataOe_n,
	// Modem and serial lines
	input wire logic       cts_n,
	input wire logic       rts_n,
	input wire logic       dtr_n,
	input wire logic       irqOut,
	input wire logic       serialOutPin,
	// Transmitter and receiver side
	input wire logic       txSerial,
	input wire logic       txEnable,
	input wire logic       txBreakMode,
	input wire logic       txStartPermit,
	input wire logic       rxSerial
);
	logic [7:0] mcr_q;
	logic [2:0] settle_q;
	logic       settled;

	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);

	// Control register shadow; checks wait until the write has surely landed
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			mcr_q    <= 8'h00;
			settle_q <= 3'h0;
		end else if ($rose(wr_n) && !$past(chipSel_n) && $past(addr) == 2'h2) begin
			mcr_q    <= $past(dataIn);
			settle_q <= 3'h0;
		end else if (settle_q != 3'h7) begin
			settle_q <= settle_q + 3'h1;
		end
	end
	assign settled = settle_q == 3'h7;

	a_reset_idle: assert property ($fell(rst) |-> rts_n && dtr_n && !irqOut && dataOe_n)
		else $error("outputs not idle after reset");
	a_line_outputs: assert property (settled |-> rts_n == !mcr_q[1] && dtr_n == !mcr_q[0])
		else $error("rts or dtr disagrees with control");
	a_irq_gated: assert property (settled && !mcr_q[6] |-> !irqOut)
		else $error("interrupt while globally disabled");
	a_break_low: assert property (settled && mcr_q[3:2] == URS_MODE_BREAK |-> !serialOutPin && txBreakMode)
		else $error("break mode not holding output low");
	a_echo_no_tx: assert property (settled && mcr_q[3:2] == URS_MODE_ECHO |-> !txEnable)
		else $error("transmitter enabled in echo");
	a_loop_route: assert property (settled && mcr_q[3:2] == URS_MODE_LOOP && mcr_q[4] |-> serialOutPin && rxSerial == txSerial)
		else $error("loop routing wrong");
	a_rx_gate: assert property (settled && !mcr_q[4] && mcr_q[3:2] != URS_MODE_LOOP |-> rxSerial)
		else $error("receiver input not blocked");
	a_cts_permit: assert property ((!cts_n) [*4] |-> txStartPermit)
		else $error("start not permitted with cts asserted");
	a_modem_irq: assert property (settled && mcr_q[6] && mcr_q[5] && $changed(cts_n) |-> ##[3:6] irqOut)
		else $error("no interrupt after cts change");

	// Main scenarios reached
	c_echo: cover property (settled && mcr_q[3:2] == URS_MODE_ECHO);
	c_loop: cover property (settled && mcr_q[3:2] == URS_MODE_LOOP && mcr_q[4]);
	c_irq: cover property ($rose(irqOut));
endmodule : urs_core_monitor

bind urs_core urs_core_monitor urs_core_monitor_inst (.clk_sys, .rst, .chipSel_n, .wr_n, .addr,
	.dataIn, .dataOe_n, .cts_n, .rts_n, .dtr_n, .irqOut, .serialOutPin, .txSerial, .txEnable,
	.txBreakMode, .txStartPermit, .rxSerial);

// ---- test/urs_modem_model.sv ----
module urs_modem_model (
	// Clock
	input  wire logic clk_sys,
	// Modem lines, idle deasserted and at mark
	output logic      cts_n,
	output logic      dsr_n,
	output logic      serialInPin
);
	timeunit 1ns;
	timeprecision 100ps;

	// Idle levels from time zero
	initial begin
		cts_n       = 1'b1;
		dsr_n       = 1'b1;
		serialInPin = 1'b1;
	end

	// Answer promptly or after a lag of whole cycles, just after an edge
	task automatic lines(input logic cts, dsr, sdata, input int lag);
		repeat (lag) @(posedge clk_sys);
		if (lag > 0) #1;
		cts_n       = cts;
		dsr_n       = dsr;
		serialInPin = sdata;
	endtask : lines
endmodule : urs_modem_model
